// File: verilog/cfm_consts.vh
`ifndef CFM_CONSTS_VH
`define CFM_CONSTS_VH
// Register byte addresses
`define CFM_ADDR_IRQ_EN 12'h000
`define CFM_ADDR_IRQ_STAT 12'h004
`define CFM_ADDR_MASK0_STD 12'h010
`define CFM_ADDR_MASK0_EXT 12'h014
`define CFM_ADDR_MASK1_STD 12'h018
`define CFM_ADDR_MASK1_EXT 12'h01c
`define CFM_ADDR_MASK2_STD 12'h020
`define CFM_ADDR_MASK2_EXT 12'h024
`define CFM_ADDR_OVF_LO 12'h030
`define CFM_ADDR_OVF_HI 12'h034
`define CFM_ADDR_MATCH 12'h040
// Field positions
`define CFM_BIT_INVALID_IE 7
`define CFM_BIT_WAKEUP_IE 6
`define CFM_BIT_ERROR_IE 5
`define CFM_BIT_FIFO_IE 3
`define CFM_BIT_OVF_IE 2
`define CFM_BIT_RXBUF_IE 1
`define CFM_BIT_TXBUF_IE 0
`define CFM_IRQ_EN_IMPL 16'h00ef
`define CFM_STD_MASK_IMPL 16'hffeb
`define CFM_BIT_ID_TYPE_MODE 3
// Reset values
`define CFM_RST_IRQ_EN 16'h0000
`define CFM_RST_MASK 16'h0000
`define CFM_RST_OVF 16'h0000
`endif

// File: verilog/cfm_filter_flags.v
`timescale 1ns/1ps
module cfm_filter_flags
(
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Events from the controller, one-cycle pulses
    input wire [7:0] event_pulse,
    // Buffer write attempts
    input wire buf_write,
    input wire [4:0] buf_index,
    input wire buf_full,
    // Filter compare request
    input wire cmp_valid,
    input wire [1:0] cmp_mask_sel,
    input wire [10:0] filter_std_id,
    input wire [17:0] filter_ext_id,
    input wire filter_extended_select,
    input wire [10:0] msg_std_id,
    input wire [17:0] msg_ext_id,
    input wire msg_is_extended,
    // Results
    output reg cmp_done,
    output reg cmp_accept,
    output reg [7:0] irq_request,
    output reg irq
);
`include "cfm_consts.vh"

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [15:0] irq_en_reg;
    reg [7:0] irq_stat_reg;
    reg [15:0] std_mask_reg [0:2];
    reg [15:0] ext_mask_reg [0:2];
    reg [31:0] ovf_reg;
    reg last_match_reg;

    wire wr_en = psel & penable & pwrite & pready;
    wire setup = psel & ~penable;
    reg [31:0] rd_next;
    reg err_next;

    // ------------------------------------------------------------
    // APB answer: no wait state, data registered in setup
    // ------------------------------------------------------------
    always @*
    begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        case (paddr)
            `CFM_ADDR_IRQ_EN: rd_next = {16'h0000, irq_en_reg};
            `CFM_ADDR_IRQ_STAT: rd_next = {24'h00_0000, irq_stat_reg};
            `CFM_ADDR_MASK0_STD: rd_next = {16'h0000, std_mask_reg[0]};
            `CFM_ADDR_MASK0_EXT: rd_next = {16'h0000, ext_mask_reg[0]};
            `CFM_ADDR_MASK1_STD: rd_next = {16'h0000, std_mask_reg[1]};
            `CFM_ADDR_MASK1_EXT: rd_next = {16'h0000, ext_mask_reg[1]};
            `CFM_ADDR_MASK2_STD: rd_next = {16'h0000, std_mask_reg[2]};
            `CFM_ADDR_MASK2_EXT: rd_next = {16'h0000, ext_mask_reg[2]};
            `CFM_ADDR_OVF_LO: rd_next = {16'h0000, ovf_reg[15:0]};
            `CFM_ADDR_OVF_HI: rd_next = {16'h0000, ovf_reg[31:16]};
            `CFM_ADDR_MATCH: rd_next = {31'h0000_0000, last_match_reg};
            default: err_next = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= setup;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= setup & err_next;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup & ~pwrite)
            prdata <= rd_next;
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en_reg <= `CFM_RST_IRQ_EN;
        else if (wr_en & (paddr == `CFM_ADDR_IRQ_EN))
            irq_en_reg <= pwdata[15:0] & `CFM_IRQ_EN_IMPL;
    end

    // ------------------------------------------------------------
    // Acceptance mask registers, one pair per mask
    // ------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < 3; m = m + 1)
        begin : g_mask
            wire std_hit = wr_en & (paddr == `CFM_ADDR_MASK0_STD + 8 * m);
            wire ext_hit = wr_en & (paddr == `CFM_ADDR_MASK0_EXT + 8 * m);
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    std_mask_reg[m] <= `CFM_RST_MASK;
                    ext_mask_reg[m] <= `CFM_RST_MASK;
                end
                else
                begin
                    if (std_hit)
                        std_mask_reg[m] <= pwdata[15:0] & `CFM_STD_MASK_IMPL;
                    if (ext_hit)
                        ext_mask_reg[m] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Overflow flags, set wins over clear
    // ------------------------------------------------------------
    localparam [31:0] OVF_RST = {`CFM_RST_OVF, `CFM_RST_OVF};

    wire ovf_hit = buf_write & buf_full;
    wire ovf_lo_wr = wr_en & (paddr == `CFM_ADDR_OVF_LO);
    wire ovf_hi_wr = wr_en & (paddr == `CFM_ADDR_OVF_HI);
    wire [31:0] ovf_set;
    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1)
        begin : g_ovf
            wire word_wr;
            wire keep_bit;
            if (b < 16)
            begin : g_lo
                assign word_wr = ovf_lo_wr;
                assign keep_bit = pwdata[b];
            end
            else
            begin : g_hi
                assign word_wr = ovf_hi_wr;
                assign keep_bit = pwdata[b - 16];
            end
            assign ovf_set[b] = ovf_hit & (buf_index == b);
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ovf_reg[b] <= OVF_RST[b];
                else if (ovf_set[b])
                    ovf_reg[b] <= 1'b1;
                else if (word_wr & ~keep_bit)
                    ovf_reg[b] <= 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt status, enables and output
    // ------------------------------------------------------------
    wire stat_wr = wr_en & (paddr == `CFM_ADDR_IRQ_STAT);
    wire [7:0] evt;
    wire [7:0] req_next;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_irq
            if (g == 4)
            begin : g_none
                assign evt[g] = 1'b0;
            end
            else if (g == `CFM_BIT_OVF_IE)
            begin : g_ovf_evt
                assign evt[g] = event_pulse[g] | (|ovf_set);
            end
            else
            begin : g_evt
                assign evt[g] = event_pulse[g];
            end
            wire clr_bit = stat_wr & pwdata[g];
            wire stat_bit_next = (irq_stat_reg[g] & ~clr_bit) | evt[g];
            assign req_next[g] = stat_bit_next & irq_en_reg[g];
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    irq_stat_reg[g] <= 1'b0;
                    irq_request[g] <= 1'b0;
                end
                else
                begin
                    irq_stat_reg[g] <= stat_bit_next;
                    irq_request[g] <= req_next[g];
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |req_next;
    end

    // ------------------------------------------------------------
    // Acceptance compare
    // ------------------------------------------------------------
    reg [15:0] sel_std;
    reg [15:0] sel_ext;
    always @*
    begin
        case (cmp_mask_sel)
            2'd0:
            begin
                sel_std = std_mask_reg[0];
                sel_ext = ext_mask_reg[0];
            end
            2'd1:
            begin
                sel_std = std_mask_reg[1];
                sel_ext = ext_mask_reg[1];
            end
            default:
            begin
                sel_std = std_mask_reg[2];
                sel_ext = ext_mask_reg[2];
            end
        endcase
    end

    wire [10:0] std_m = sel_std[15:5];
    wire [17:0] ext_m = {sel_std[1:0], sel_ext};
    wire [10:0] std_diff;
    wire [17:0] ext_diff;
    genvar k;
    generate
        for (k = 0; k < 18; k = k + 1)
        begin : g_cmp
            if (k < 11)
            begin : g_std
                assign std_diff[k] = (filter_std_id[k] ^ msg_std_id[k]) & std_m[k];
            end
            assign ext_diff[k] = (filter_ext_id[k] ^ msg_ext_id[k]) & ext_m[k];
        end
    endgenerate

    wire std_eq = ~|std_diff;
    wire ext_eq = ~|ext_diff;
    wire id_eq = std_eq & (~msg_is_extended | ext_eq);
    wire type_ok = ~sel_std[`CFM_BIT_ID_TYPE_MODE]
                   | (msg_is_extended == filter_extended_select);
    wire accept = id_eq & type_ok;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmp_done <= 1'b0;
        else
            cmp_done <= cmp_valid;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmp_accept <= 1'b0;
        else
            cmp_accept <= cmp_valid & accept;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_match_reg <= 1'b0;
        else if (cmp_valid)
            last_match_reg <= accept;
    end

endmodule // cfm_filter_flags

// File: dv/cfm_assertions.sv
`timescale 1ns/1ps
// ---
// Port checks
// ---
module cfm_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Compare and interrupts
    input wire cmp_valid,
    input wire cmp_done,
    input wire cmp_accept,
    input wire [7:0] irq_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("slverr");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pulse");
    a_done_cmp: assert property (cmp_valid |=> cmp_done) else $error("done");
    a_done_only: assert property (!cmp_valid |=> !cmp_done) else $error("spurious");
    a_accept_done: assert property (cmp_accept |-> cmp_done) else $error("accept");
    a_bit4_zero: assert property (irq_request[4] == 1'b0) else $error("bit4");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper");
    c_slverr: cover property (pslverr);
    c_accept: cover property (cmp_accept);
    c_ovf: cover property (irq_request[2]);
endmodule // cfm_checker
bind cfm_filter_flags cfm_checker u_chk (.*);

// File: dv/cfm_rx_node.sv
`timescale 1ns/1ps
// ---
// Receive side with buffer occupancy
// ---
module cfm_rx_node (
    // Control
    input wire pclk,
    input wire presetn,
    input wire req,
    input wire [4:0] idx,
    // To block
    output reg buf_write,
    output reg [4:0] buf_index,
    output reg buf_full
);
    reg [31:0] occ_reg;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            occ_reg <= 32'h0;
        else if (req)
            occ_reg[idx] <= 1'b1;
        buf_write <= presetn && req;
        buf_index <= req ? idx : ~idx;
        buf_full <= req ? occ_reg[idx] : ~occ_reg[idx]; // Second delivery hits full
    end
endmodule // cfm_rx_node

// File: dv/cfm_filter_flags_bench.sv
`timescale 1ns/1ps
`include "cfm_consts.vh"
module cfm_filter_flags_bench;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_req = 0, cmp_valid = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rdata;
    reg [7:0] event_pulse = 0;
    reg [4:0] rx_idx = 0;
    reg [1:0] sel = 0;
    reg [10:0] fs = 0, ms = 0;
    reg [17:0] fe = 0, me = 0;
    reg fx = 0, mx = 0;
    reg rerr = 0;
    wire [31:0] prdata;
    wire pready, pslverr, buf_write, buf_full, cmp_done, cmp_accept, irq;
    wire [4:0] buf_index;
    wire [7:0] irq_request;
    integer err_count = 0, samples_checked = 0, i;
    cfm_rx_node node (.pclk(pclk), .presetn(presetn), .req(rx_req), .idx(rx_idx),
        .buf_write(buf_write), .buf_index(buf_index), .buf_full(buf_full));
    cfm_filter_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_pulse(event_pulse), .buf_write(buf_write),
        .buf_index(buf_index), .buf_full(buf_full), .cmp_valid(cmp_valid),
        .cmp_mask_sel(sel), .filter_std_id(fs), .filter_ext_id(fe),
        .filter_extended_select(fx), .msg_std_id(ms), .msg_ext_id(me),
        .msg_is_extended(mx), .cmp_done(cmp_done), .cmp_accept(cmp_accept),
        .irq_request(irq_request), .irq(irq));
    initial forever #5 pclk = ~pclk;
    task chk(input [31:0] g, input [31:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    end
    endtask
    task pulse(input [7:0] v);
    begin
        @(posedge pclk);
        event_pulse <= v;
        @(posedge pclk);
        event_pulse <= 0;
        repeat (2) @(posedge pclk);
        #1;
    end
    endtask
    task rx(input [4:0] n);
    begin
        repeat (2)
        begin
            @(posedge pclk);
            {rx_req, rx_idx} <= {1'b1, n};
            @(posedge pclk);
            rx_req <= 0;
        end
        repeat (3) @(posedge pclk);
    end
    endtask
    task cmp(input [1:0] s, input [28:0] f, input a, input [28:0] m, input b, input e);
    begin
        @(posedge pclk);
        {cmp_valid, sel, fs, fe, fx, ms, me, mx} <= {1'b1, s, f, a, m, b};
        @(posedge pclk);
        cmp_valid <= 0;
        #1;
        chk({cmp_done, cmp_accept}, {1'b1, e});
    end
    endtask
    task t_regs;
    begin
        apb(1, `CFM_ADDR_IRQ_EN, 32'hffffffff);
        apb(0, `CFM_ADDR_IRQ_EN, 0);
        chk(rdata, 32'h00ef);
        apb(1, `CFM_ADDR_MASK1_STD, 32'hffffffff);
        apb(0, `CFM_ADDR_MASK1_STD, 0);
        chk(rdata, 32'hffeb);
        apb(1, `CFM_ADDR_MASK2_EXT, 32'hffffffff);
        apb(0, `CFM_ADDR_MASK2_EXT, 0);
        chk(rdata, 32'hffff);
        apb(0, 12'h0fc, 0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
        apb(1, `CFM_ADDR_IRQ_EN, 0);
        $display("t_regs done");
    end
    endtask
    task t_ovf;
    begin
        rx(3);
        apb(0, `CFM_ADDR_OVF_LO, 0);
        chk(rdata, 32'h8);
        apb(1, `CFM_ADDR_OVF_LO, 32'hffff);
        apb(0, `CFM_ADDR_OVF_LO, 0);
        chk(rdata, 32'h8);
        apb(1, `CFM_ADDR_OVF_LO, 0);
        rx(20);
        apb(0, `CFM_ADDR_OVF_LO, 0);
        chk(rdata, 32'h0);
        apb(0, `CFM_ADDR_OVF_HI, 0);
        chk(rdata, 32'h10);
        $display("t_ovf done");
    end
    endtask
    task t_irq;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            pulse(8'h1 << i);
            chk(irq_request, 0);
            apb(1, `CFM_ADDR_IRQ_EN, 32'h1 << i);
            pulse(0);
            chk({irq, irq_request}, (i == 4) ? 0 : 9'h100 | (9'h1 << i));
            apb(1, `CFM_ADDR_IRQ_STAT, 32'hff);
            pulse(0);
            chk(irq, 0);
        end
        $display("t_irq done");
    end
    endtask
    task t_filter;
    begin
        apb(1, `CFM_ADDR_MASK0_STD, 32'hffe0);
        apb(1, `CFM_ADDR_MASK0_EXT, 0);
        cmp(0, {11'h123, 18'h0}, 0, {11'h122, 18'h0}, 0, 0);
        cmp(0, {11'h123, 18'h0}, 0, {11'h123, 18'h3ffff}, 1, 1);
        apb(1, `CFM_ADDR_MASK1_STD, 0);
        cmp(1, {11'h7ff, 18'h0}, 0, 29'h0, 0, 1);
        apb(1, `CFM_ADDR_MASK2_STD, 32'hffeb);
        cmp(2, {11'h55, 18'h0}, 1, {11'h55, 18'h0}, 0, 0);
        cmp(2, {11'h55, 18'h3ffff}, 1, {11'h55, 18'h3ffff}, 1, 1);
        apb(0, `CFM_ADDR_MATCH, 0);
        chk(rdata, 32'h1);
        cmp(3, {11'h55, 18'h10000}, 1, {11'h55, 18'h0}, 1, 0);
        cmp(2, {11'h55, 18'h1}, 1, {11'h55, 18'h0}, 1, 0);
        apb(0, `CFM_ADDR_MATCH, 0);
        chk(rdata, 32'h0);
        $display("t_filter done");
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    initial
    begin
        #400000;
        err_count = err_count + 1;
        print_verdict;
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_ovf;
        t_irq;
        t_filter;
        print_verdict;
    end
endmodule // cfm_filter_flags_bench
